// >>> src/frs_pkg.sv
// frs_pkg: constants and types for the fifo read-side controller
package frs_pkg;
  localparam int unsigned FRS_DW    = 36;
  localparam int unsigned FRS_AW    = 6;
  localparam int unsigned FRS_OFS_W = 24;
  localparam logic [FRS_AW:0] FRS_DEPTH = 7'h40;

  // register byte addresses (word aligned)
  localparam logic [3:0] FRS_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] FRS_ADDR_EOFS   = 4'h4;
  localparam logic [3:0] FRS_ADDR_FOFS   = 4'h8;
  localparam logic [3:0] FRS_ADDR_STATUS = 4'hC;

  // control and status register field positions
  localparam int unsigned FRS_CTRL_WSEL_LSB  = 0;
  localparam int unsigned FRS_CTRL_LARGE_BIT = 2;
  localparam int unsigned FRS_ST_COUNT_LSB   = 8;
  localparam int unsigned FRS_ST_SEQ_LSB     = 16;

  // values after reset
  localparam logic [2:0]           FRS_CTRL_RST = 3'h0;
  localparam logic [FRS_OFS_W-1:0] FRS_EOFS_RST = 24'h000007;
  localparam logic [FRS_OFS_W-1:0] FRS_FOFS_RST = 24'h000007;
  localparam logic [2:0]           FRS_SEQ_RST  = 3'h0;

  // output bus width selection
  localparam logic [1:0] FRS_W36 = 2'h0;
  localparam logic [1:0] FRS_W18 = 2'h1;
  localparam logic [1:0] FRS_W9  = 2'h2;

  // offset read-back lengths in words
  localparam logic [2:0] FRS_NW_2 = 3'h2;
  localparam logic [2:0] FRS_NW_4 = 3'h4;
  localparam logic [2:0] FRS_NW_6 = 3'h6;

  localparam logic [1:0] FRS_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    FRS_NORMAL = 2'b00,
    FRS_RETX   = 2'b01,
    FRS_SETUP  = 2'b11
  } frs_mode_t;
endpackage

// >>> src/frs_read_ctrl.sv
// frs_read_ctrl: fifo read side with offset read-back and retransmit
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`default_nettype none
module frs_read_ctrl
  import frs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hsel,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              master_reset_n,
  input  wire logic              partial_reset_n,
  input  wire logic              fall_through_select_pin,
  input  wire logic              wr_en_n,
  input  wire logic [FRS_DW-1:0] wr_data,
  input  wire logic              rd_en_n,
  input  wire logic              offset_access_select_n,
  input  wire logic              mark,
  input  wire logic              replay_request_n,
  output logic [FRS_DW-1:0]      data_out_bus,
  output logic                   empty_flag_n,
  output logic                   out_ready_n,
  output logic                   full_flag_n,
  output logic                   almost_empty_flag_n,
  output logic                   almost_full_flag_n
);

  //////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [FRS_DW+7:0]    sync1;
    logic [FRS_DW+7:0]    sync2;
    logic                 fall_through_mode;
    frs_mode_t            mode;
    logic [FRS_AW:0]      wr_ptr;
    logic [FRS_AW:0]      rd_ptr;
    logic [FRS_AW:0]      mark_ptr;
    logic [2:0]           seq;
    logic                 out_valid;
    logic [FRS_DW-1:0]    dout;
    logic [2:0]           ctrl;
    logic [FRS_OFS_W-1:0] empty_ofs;
    logic [FRS_OFS_W-1:0] full_ofs;
    logic                 dp_wr;
    logic [3:0]           dp_addr;
    logic [31:0]          rdata;
  } frs_state_t;

  frs_state_t state_reg;
  frs_state_t state_next;
  logic [FRS_DW-1:0] mem [0:FRS_DEPTH-1];

  //////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [2:0] words_total(input logic [2:0] c);
    case (c[1:0])
      FRS_W18: words_total = c[FRS_CTRL_LARGE_BIT] ? FRS_NW_4 : FRS_NW_2;
      FRS_W9:  words_total = c[FRS_CTRL_LARGE_BIT] ? FRS_NW_6 : FRS_NW_4;
      default: words_total = FRS_NW_2;
    endcase
  endfunction

  function automatic logic [FRS_DW-1:0] ofs_word(
    input logic [FRS_OFS_W-1:0] ofs,
    input logic [1:0]           k,
    input logic [1:0]           wsel
  );
    logic [FRS_DW-1:0] wide;
    wide = {{(FRS_DW-FRS_OFS_W){1'b0}}, ofs};
    case (wsel)
      FRS_W18: ofs_word = {18'h00000, wide[k*18 +: 18]};
      FRS_W9:  ofs_word = {27'h0000000, wide[k*9 +: 9]};
      default: ofs_word = wide;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // synchronised pins
  logic              s_rd_n, s_ofs_sel_n, s_mark, s_replay_n;
  logic              s_ft_sel, s_mreset_n, s_preset_n, s_wr_n;
  logic [FRS_DW-1:0] s_wdata;
  assign {s_wdata, s_wr_n, s_preset_n, s_mreset_n, s_ft_sel,
          s_replay_n, s_mark, s_ofs_sel_n, s_rd_n} = state_reg.sync2;

  logic [FRS_AW:0]   count;
  logic [2:0]        nw;
  logic [2:0]        half;
  logic [1:0]        k_idx;
  logic [FRS_DW-1:0] ofs_val;
  logic              offs_fire;
  logic              wr_fire;
  logic              rd_fire;
  logic              mark_fire;
  logic              replay_fire;
  logic              setup_done;
  logic              blocked;
  logic [31:0]       rd_mux;
  logic              addr_ok;

  always_comb
  begin
    count     = state_reg.wr_ptr - state_reg.rd_ptr;
    nw        = words_total(state_reg.ctrl);
    half      = {1'b0, nw[2:1]};
    k_idx     = (state_reg.seq < half) ? state_reg.seq[1:0]
                                       : 2'(state_reg.seq - half);
    ofs_val   = ofs_word((state_reg.seq < half) ? state_reg.empty_ofs
                                                : state_reg.full_ofs,
                         k_idx, state_reg.ctrl[1:0]);
    // offset access needs both strobes low, in either mode
    offs_fire = !s_rd_n && !s_ofs_sel_n && s_mreset_n && s_preset_n;
    // write pointer stops at the marked word
    blocked   = (state_reg.mode != FRS_NORMAL) &&
                (state_reg.wr_ptr[FRS_AW-1:0] ==
                 state_reg.mark_ptr[FRS_AW-1:0]) && (count != '0);
    wr_fire   = !s_wr_n && (count != FRS_DEPTH) && !blocked &&
                s_mreset_n && s_preset_n;
    mark_fire = (state_reg.mode == FRS_NORMAL) && s_mark &&
                (state_reg.fall_through_mode ? state_reg.out_valid
                                             : (count != '0));
    replay_fire = (state_reg.mode == FRS_RETX) && s_mark && !s_replay_n;
    setup_done  = (state_reg.mode == FRS_SETUP) && s_mark && s_replay_n;
    rd_fire     = !s_rd_n && s_ofs_sel_n && (count != '0) &&
                  (state_reg.mode != FRS_SETUP) && !setup_done &&
                  s_mreset_n && s_preset_n;

    addr_ok = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0);
    case (haddr[3:0])
      FRS_ADDR_CTRL:   rd_mux = {29'h00000000, state_reg.ctrl};
      FRS_ADDR_EOFS:   rd_mux = {8'h00, state_reg.empty_ofs};
      FRS_ADDR_FOFS:   rd_mux = {8'h00, state_reg.full_ofs};
      FRS_ADDR_STATUS: rd_mux = {13'h0000, state_reg.seq,
                                 1'b0, count, 4'h0,
                                 state_reg.out_valid, state_reg.mode,
                                 state_reg.fall_through_mode};
      default:         rd_mux = 32'h00000000;
    endcase
    if (!addr_ok)
      rd_mux = 32'h00000000;

    state_next       = state_reg;
    state_next.sync1 = {wr_data, wr_en_n, partial_reset_n, master_reset_n,
                        fall_through_select_pin, replay_request_n, mark,
                        offset_access_select_n, rd_en_n};
    state_next.sync2 = state_reg.sync1;

    // bus slave: address phase captures, data phase writes
    state_next.dp_wr = 1'b0;
    if (hsel && hready && (htrans == FRS_HTRANS_NONSEQ))
    begin
      state_next.dp_wr   = hwrite && addr_ok;
      state_next.dp_addr = haddr[3:0];
      state_next.rdata   = rd_mux;
    end
    if (state_reg.dp_wr)
    begin
      case (state_reg.dp_addr)
        FRS_ADDR_CTRL: state_next.ctrl      = hwdata[2:0];
        FRS_ADDR_EOFS: state_next.empty_ofs = hwdata[FRS_OFS_W-1:0];
        FRS_ADDR_FOFS: state_next.full_ofs  = hwdata[FRS_OFS_W-1:0];
        default: ;
      endcase
    end

    if (wr_fire)
      state_next.wr_ptr = state_reg.wr_ptr + 7'h01;

    // offset read-back walks the sequence and takes the output
    if (offs_fire)
    begin
      state_next.dout = ofs_val;
      state_next.seq  = (state_reg.seq + 3'h1 == nw) ? FRS_SEQ_RST
                                                     : state_reg.seq + 3'h1;
    end
    else if (state_reg.fall_through_mode)
    begin
      if (setup_done)
      begin
        state_next.dout      = mem[state_reg.rd_ptr[FRS_AW-1:0]];
        state_next.rd_ptr    = state_reg.rd_ptr + 7'h01;
        state_next.out_valid = 1'b1;
      end
      else if ((!state_reg.out_valid || rd_fire) &&
               state_reg.mode != FRS_SETUP)
      begin
        if (count != '0)
        begin
          state_next.dout      = mem[state_reg.rd_ptr[FRS_AW-1:0]];
          state_next.rd_ptr    = state_reg.rd_ptr + 7'h01;
          state_next.out_valid = 1'b1;
        end
        else
          state_next.out_valid = 1'b0;
      end
    end
    else if (rd_fire)
    begin
      state_next.dout   = mem[state_reg.rd_ptr[FRS_AW-1:0]];
      state_next.rd_ptr = state_reg.rd_ptr + 7'h01;
    end

    // retransmit mode sequencing
    if (!s_mark)
      state_next.mode = FRS_NORMAL;
    else if (mark_fire)
    begin
      state_next.mode     = FRS_RETX;
      state_next.mark_ptr = state_reg.rd_ptr - 7'h01;
    end
    else if (replay_fire || (state_reg.mode == FRS_SETUP && !s_replay_n))
    begin
      state_next.mode      = FRS_SETUP;
      state_next.rd_ptr    = state_reg.mark_ptr;
      state_next.out_valid = 1'b0;
    end
    else if (setup_done)
      state_next.mode = FRS_RETX;

    if (!s_preset_n || !s_mreset_n)
    begin
      state_next.wr_ptr    = '0;
      state_next.rd_ptr    = '0;
      state_next.mark_ptr  = '0;
      state_next.out_valid = 1'b0;
      state_next.dout      = '0;
      state_next.mode      = FRS_NORMAL;
    end
    if (!s_mreset_n)
    begin
      state_next.seq               = FRS_SEQ_RST;
      state_next.fall_through_mode = s_ft_sel;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg           <= '0;
      state_reg.sync1     <= '1;
      state_reg.sync2     <= '1;
      state_reg.mode      <= FRS_NORMAL;
      state_reg.ctrl      <= FRS_CTRL_RST;
      state_reg.empty_ofs <= FRS_EOFS_RST;
      state_reg.full_ofs  <= FRS_FOFS_RST;
      state_reg.seq       <= FRS_SEQ_RST;
    end
    else
      state_reg <= state_next;
  end

  always_ff @(posedge sys_clk)
  begin
    if (wr_fire)
      mem[state_reg.wr_ptr[FRS_AW-1:0]] <= s_wdata;
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  assign hrdata       = state_reg.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign data_out_bus = state_reg.dout;
  // empty flag low while the replay setup runs
  assign empty_flag_n = !state_reg.fall_through_mode && (count != '0) &&
                        (state_reg.mode != FRS_SETUP);
  assign out_ready_n  = !(state_reg.fall_through_mode &&
                          state_reg.out_valid);
  assign full_flag_n  = (count != FRS_DEPTH) && !blocked;
  assign almost_empty_flag_n =
    ({{(FRS_OFS_W-FRS_AW-1){1'b0}}, count} > state_reg.empty_ofs);
  assign almost_full_flag_n =
    ({{(FRS_OFS_W-FRS_AW-1){1'b0}}, FRS_DEPTH - count} >
     state_reg.full_ofs);

  //////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_offset_seq_wrap: assert property (
    offs_fire && s_mreset_n |=> state_reg.seq ==
      (($past(state_reg.seq) + 3'h1 == $past(nw)) ? 3'h0
                                                  : $past(state_reg.seq) + 3'h1))
    else $error("offset sequence did not advance or wrap");

  a_offset_out_word: assert property (
    offs_fire |=> state_reg.dout == $past(ofs_val))
    else $error("offset word not placed on output");

  a_pause_holds_seq: assert property (
    !offs_fire && s_mreset_n |=> $stable(state_reg.seq))
    else $error("offset sequence moved while paused");

  a_mark_enters: assert property (
    mark_fire && s_mreset_n && s_preset_n |=> state_reg.mode == FRS_RETX &&
      state_reg.mark_ptr == $past(state_reg.rd_ptr) - 7'h01)
    else $error("mark did not record output word");

  a_mark_low_exits: assert property (
    !s_mark |=> state_reg.mode == FRS_NORMAL)
    else $error("retransmit mode kept with mark low");

  a_replay_rewinds: assert property (
    replay_fire && s_mreset_n && s_preset_n |=>
      state_reg.mode == FRS_SETUP &&
      state_reg.rd_ptr == $past(state_reg.mark_ptr))
    else $error("replay did not rewind read pointer");

  a_setup_flags: assert property (
    state_reg.mode == FRS_SETUP |-> !empty_flag_n && out_ready_n)
    else $error("flags wrong during replay setup");

  a_no_overwrite: assert property (
    wr_fire && state_reg.mode != FRS_NORMAL && count != '0 |->
      state_reg.wr_ptr[FRS_AW-1:0] != state_reg.mark_ptr[FRS_AW-1:0])
    else $error("write reached the marked word");

  a_ft_first_word: assert property (
    state_reg.fall_through_mode && setup_done && s_mreset_n && s_preset_n
      |=> state_reg.out_valid && !out_ready_n)
    else $error("first replay word not preloaded");

  a_mreset_clears_seq: assert property (
    !s_mreset_n |=> state_reg.seq == 3'h0)
    else $error("master reset left offset pointer");

endmodule // frs_read_ctrl
`default_nettype wire

// >>> verif/frs_host_model.sv
// frs_host_model: host logic on the fifo read and write pins
`timescale 1ns/1ns
`default_nettype none
module frs_host_model
(
  input  wire logic   sys_clk,
  output logic        rd_en_n,
  output logic        offset_access_select_n,
  output logic        mark,
  output logic        replay_request_n,
  output logic        wr_en_n,
  output logic [35:0] wr_data
);
  // idle levels on every pin, called once at the start
  task automatic idle();
    rd_en_n <= 1'b1;
    offset_access_select_n <= 1'b1;
    mark <= 1'b0;
    replay_request_n <= 1'b1;
    wr_en_n <= 1'b1;
    wr_data <= 36'h0;
  endtask
////////////////////////////////////////
  // ends off the edge so callers see settled outputs
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // one enabled edge, then idle cycles before the next access
  task automatic rd_pulse(input logic sel_n);
    @(posedge sys_clk);
    rd_en_n <= 1'b0;
    offset_access_select_n <= sel_n;
    @(posedge sys_clk);
    rd_en_n <= 1'b1;
    offset_access_select_n <= 1'b1;
    tick(4);
  endtask
  task automatic wr_word(input logic [35:0] d);
    @(posedge sys_clk);
    wr_en_n <= 1'b0;
    wr_data <= d;
    @(posedge sys_clk);
    wr_en_n <= 1'b1;
    wr_data <= ~d;
  endtask
  // reads are held off whenever mark or replay moves
  task automatic pins(input logic m, input logic rq_n);
    @(posedge sys_clk);
    rd_en_n <= 1'b1;
    mark <= m;
    replay_request_n <= rq_n;
    tick(4);
  endtask
endmodule // frs_host_model
`default_nettype wire

// >>> verif/frs_read_ctrl_tb_top.sv
// frs_read_ctrl_tb_top: self-checking bench for the fifo read side
`timescale 1ns/1ns
`default_nettype none
module frs_read_ctrl_tb_top
  import frs_pkg::*;
;
  localparam logic [23:0] EO = 24'hA5C3E1;
  localparam logic [23:0] FO = 24'h3B5D79;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              sel_on = 1'b1;
  logic              hwrite;
  logic              hsel;
  logic              master_reset_n;
  logic              partial_reset_n;
  logic              fall_through_select_pin;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic              hreadyout, hresp, empty_flag_n, out_ready_n;
  logic              full_flag_n, almost_empty_flag_n, almost_full_flag_n;
  logic              rd_en_n, offset_access_select_n, mark;
  logic              replay_request_n, wr_en_n;
  logic [FRS_DW-1:0] data_out_bus, wr_data;
  int                errors = 0;
  int                checks_done = 0;
  always #50 sys_clk = ~sys_clk;
  frs_host_model host
  (
    .sys_clk(sys_clk), .rd_en_n(rd_en_n), .mark(mark), .wr_en_n(wr_en_n),
    .offset_access_select_n(offset_access_select_n), .wr_data(wr_data),
    .replay_request_n(replay_request_n)
  );
  frs_read_ctrl uut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .master_reset_n(master_reset_n),
    .partial_reset_n(partial_reset_n),
    .fall_through_select_pin(fall_through_select_pin),
    .wr_en_n(wr_en_n), .wr_data(wr_data), .rd_en_n(rd_en_n),
    .offset_access_select_n(offset_access_select_n), .mark(mark),
    .replay_request_n(replay_request_n), .data_out_bus(data_out_bus),
    .empty_flag_n(empty_flag_n), .out_ready_n(out_ready_n),
    .full_flag_n(full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n)
  );
////////////////////////////////////////
  function automatic logic [35:0] dat(input int i);
    dat = 36'h9A0000000 + 36'(i);
  endfunction
  function automatic logic [35:0] ofs_word(input logic [23:0] o,
                                          input int k, input int w);
    ofs_word = ({12'h0, o} >> (k * w)) & ((36'h1 << w) - 36'h1);
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t %s: %h not %h", $time, m, got, exp);
    end
  endtask
  task automatic bus_idle();
    hwrite <= 1'b0;
    hsel <= 1'b0;
    master_reset_n <= 1'b1;
    partial_reset_n <= 1'b1;
    fall_through_select_pin <= 1'b0;
    htrans <= 2'h0;
    hsize <= 3'h0;
    haddr <= 32'h0;
    hwdata <= 32'h0;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n < 100)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 100)
    begin
      errors++;
      $display("[FAIL] %0t bus stalled", $time);
      test_done();
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    hsel <= sel_on;
    htrans <= FRS_HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic pin_reset(input logic part, input logic ft);
    @(posedge sys_clk);
    fall_through_select_pin <= ft;
    master_reset_n <= part;
    partial_reset_n <= !part;
    host.tick(4);
    @(posedge sys_clk);
    master_reset_n <= 1'b1;
    partial_reset_n <= 1'b1;
    host.tick(4);
  endtask
////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] r;
    for (int i = 0; i < 5; i++)
    begin
      ahb(1'b0, 32'(i * 4), 32'h0, r);
      chk(36'(r), (i == 1 || i == 2) ? 36'h7 : 36'h0, "reset");
    end
    chk(36'(hresp), 36'h0, "okay response");
    chk(36'(almost_empty_flag_n), 36'h0, "almost empty at reset");
    chk(36'(almost_full_flag_n), 36'h1, "almost full at reset");
    ahb(1'b1, 32'h4, {8'h0, EO}, r);
    ahb(1'b1, 32'h8, {8'h0, FO}, r);
    sel_on = 1'b0;
    ahb(1'b1, 32'h4, 32'h0, r);
    sel_on = 1'b1;
    ahb(1'b0, 32'h4, 32'h0, r);
    chk(36'(r), 36'(EO), "deselected write ignored");
    $display("register test done");
  endtask
  task automatic t_ofs(input logic [2:0] ctl, input int n, input int w,
                       input logic ft);
    logic [31:0] r;
    logic [35:0] e;
    int j;
    pin_reset(1'b0, ft);
    ahb(1'b1, 32'h0, {29'h0, ctl}, r);
    ahb(1'b0, 32'hC, 32'h0, r);
    chk(36'(r[0]), 36'(ft), "mode pin");
    for (int i = 0; i <= n; i++)
    begin
      j = i % n;
      e = ofs_word(j < n / 2 ? EO : FO, j % (n / 2), w);
      host.rd_pulse(1'b0);
      chk(data_out_bus, e, "offset");
      if (i == 0 && !ft)
      begin
        host.wr_word(36'h5A5A5A5A5);
        host.tick(4);
        host.rd_pulse(1'b1);
        chk(data_out_bus, 36'h5A5A5A5A5, "pause read");
      end
    end
    $display("offset test done");
  endtask
  task automatic t_prst();
    logic [31:0] r;
    pin_reset(1'b0, 1'b0);
    ahb(1'b1, 32'h0, 32'h0, r);
    host.rd_pulse(1'b0);
    pin_reset(1'b1, 1'b0);
    host.rd_pulse(1'b0);
    chk(data_out_bus, 36'(FO), "partial reset");
    $display("partial reset test done");
  endtask
  task automatic t_retx_std();
    logic [31:0] r;
    int m;
    pin_reset(1'b0, 1'b0);
    ahb(1'b1, 32'h4, 32'h8, r);
    ahb(1'b1, 32'h8, 32'h8, r);
    for (int i = 0; i < 12; i++)
      host.wr_word(dat(i));
    host.rd_pulse(1'b1);
    host.pins(1'b1, 1'b1);
    ahb(1'b0, 32'hC, 32'h0, r);
    chk(36'(r[2:1]), 36'h1, "enter");
    chk(36'(almost_empty_flag_n), 36'h1, "above empty offset");
    chk(36'(almost_full_flag_n), 36'h1, "below full offset");
    host.rd_pulse(1'b1);
    host.rd_pulse(1'b1);
    for (int i = 12; i < 72; i++)
      host.wr_word(dat(i));
    host.tick(4);
    chk(36'(full_flag_n), 36'h0, "held at mark");
    chk(36'(almost_full_flag_n), 36'h0, "almost full near top");
    for (int i = 0; i < 3; i++)
    begin
      if (i == 2)
      begin
        host.pins(1'b0, 1'b1);
        host.pins(1'b1, 1'b1);
      end
      m = (i == 2) ? 1 : 0;
      host.pins(1'b1, 1'b0);
      chk(36'(empty_flag_n), 36'h0, "empty in setup");
      ahb(1'b0, 32'hC, 32'h0, r);
      chk(36'(r[2:1]), 36'h3, "setup");
      host.pins(1'b1, 1'b1);
      chk(36'(empty_flag_n), 36'h1, "setup over");
      chk(data_out_bus, dat(i == 0 ? 2 : 1), "no read");
      host.rd_pulse(1'b1);
      chk(data_out_bus, dat(m), "first");
      host.rd_pulse(1'b1);
      chk(data_out_bus, dat(m + 1), "second");
    end
    host.pins(1'b0, 1'b1);
    ahb(1'b0, 32'hC, 32'h0, r);
    chk(36'(r[2:1]), 36'h0, "leave");
    $display("standard retransmit test done");
  endtask
  task automatic t_retx_ft();
    logic [31:0] r;
    pin_reset(1'b0, 1'b1);
    for (int i = 0; i < 12; i++)
      host.wr_word(dat(i));
    host.tick(4);
    chk(data_out_bus, dat(0), "fall through");
    host.pins(1'b1, 1'b1);
    ahb(1'b0, 32'hC, 32'h0, r);
    chk(36'(r[2:0]), 36'h3, "ft enter");
    for (int i = 0; i < 2; i++)
    begin
      host.rd_pulse(1'b1);
      chk(data_out_bus, dat(1), "ft next");
      host.pins(1'b1, 1'b0);
      chk(36'(out_ready_n), 36'h1, "ready in setup");
      host.pins(1'b1, 1'b1);
      chk(36'(out_ready_n), 36'h0, "ready after");
      chk(data_out_bus, dat(0), "preload");
    end
    host.pins(1'b0, 1'b1);
    ahb(1'b0, 32'hC, 32'h0, r);
    chk(36'(r[2:1]), 36'h0, "ft leave");
    $display("fall-through retransmit test done");
  endtask
////////////////////////////////////////
  initial
  begin
    bus_idle();
    host.idle();
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_ofs(3'h0, 2, 36, 1'b0);
    t_ofs(3'h1, 2, 18, 1'b0);
    t_ofs(3'h5, 4, 18, 1'b0);
    t_ofs(3'h2, 4, 9, 1'b0);
    t_ofs(3'h6, 6, 9, 1'b0);
    t_ofs(3'h0, 2, 36, 1'b1);
    t_prst();
    t_retx_std();
    t_retx_ft();
    test_done();
  end
endmodule // frs_read_ctrl_tb_top
`default_nettype wire
